// File: cfg_cmd_map.svh
// Command codes, field positions, fixed exponents and accepted code windows
// for the configuration command bank.
// Assumes the including file wants these as plain `define macros.
`ifndef CFG_CMD_MAP_SVH
`define CFG_CMD_MAP_SVH

// ****************************************************************
// Command codes
// ****************************************************************
`define CMD_FREQ 8'h33
`define CMD_TURNON 8'h35
`define CMD_GAIN 8'h38
`define CMD_OFFSET 8'h39
`define CMD_OVLIM 8'h40

// ****************************************************************
// Page and phase selections
// ****************************************************************
`define PAGE_A 8'h00
`define PAGE_B 8'h01
`define PAGE_ALL 8'hFF
`define PHASE_ALL 8'hFF
`define PHASE_TOTAL 8'h80

// ****************************************************************
// Field layout
// ****************************************************************
`define EXP_MSB 15
`define EXP_LSB 11
`define MAN_MSB 10
`define MAN_LSB 0
`define FREQ_EXP 5'b00000
`define TURNON_EXP 5'b11110
`define GAIN_EXP 5'b11010
`define OFFSET_EXP 5'b11101

// ****************************************************************
// Accepted code windows
// ****************************************************************
`define FREQ_MIN 16'h012C
`define FREQ_MAX 16'h03E8
`define FREQ_STEP 11'h032
`define TURNON_LOW 16'hF010
`define TURNON_MIN 16'hF015
`define TURNON_MAX 16'hF02D
`define TURNON_STEP 16'h0004
`define GAIN_MIN 16'hD131
`define GAIN_MAX 16'hD150
`define OFS_POS_MIN 16'hE800
`define OFS_POS_MAX 16'hE808
`define OFS_NEG_MIN 16'hEFF9
`define OFS_NEG_MAX 16'hEFFF
`define OFS_TPOS_MAX 16'hE820
`define OFS_TNEG_MIN 16'hEFE2
`define OFS_TNEG_MAX 16'hEFFE

`endif

// File: cfg_cmd_pkg.sv
// Types shared by the configuration command bank and its code checker.
// Assumes cfg_cmd_map.svh supplies the numeric constants.
package cfg_cmd_pkg;

    // Which register a command addresses, one-hot.
    typedef enum logic [5:0] {
        SEL_NONE = 6'b000001,
        SEL_FREQ = 6'b000010,
        SEL_TURNON = 6'b000100,
        SEL_GAIN = 6'b001000,
        SEL_OFFSET = 6'b010000,
        SEL_OVLIM = 6'b100000
    } sel_t;

endpackage : cfg_cmd_pkg

// File: code_window_check.sv
// Combinational check of a written word against a register's accepted codes.
// Assumes the caller qualifies the result with the command and page checks.
`timescale 1ns/1ps
`default_nettype none
`include "cfg_cmd_map.svh"

module code_window_check
(
    input wire cfg_cmd_pkg::sel_t sel,
    input wire logic total,
    input wire logic [15:0] word,
    output logic ok
);
    import cfg_cmd_pkg::*;

    logic [10:0] freq_diff;
    logic [15:0] turnon_diff;
    logic ofs_single;
    logic ofs_total;

    // The full word is compared, so a wrong exponent never slips through.
    always_comb
    begin
        freq_diff = 11'(word - `FREQ_MIN);
        turnon_diff = word - `TURNON_MIN;
        ofs_single = (word >= `OFS_POS_MIN && word <= `OFS_POS_MAX) ||
                     (word >= `OFS_NEG_MIN && word <= `OFS_NEG_MAX);
        ofs_total = !word[0] &&
                    ((word >= `OFS_POS_MIN && word <= `OFS_TPOS_MAX) ||
                     (word >= `OFS_TNEG_MIN && word <= `OFS_TNEG_MAX));
        ok = 1'b0;
        case (sel)
            SEL_FREQ:
                ok = word >= `FREQ_MIN && word <= `FREQ_MAX &&
                     (freq_diff % `FREQ_STEP) == 11'h000;
            SEL_TURNON:
                ok = word == `TURNON_LOW ||
                     (word >= `TURNON_MIN && word <= `TURNON_MAX &&
                      turnon_diff[1:0] == 2'h0);
            SEL_GAIN:
                ok = word >= `GAIN_MIN && word <= `GAIN_MAX;
            SEL_OFFSET:
                ok = total ? ofs_total : ofs_single;
            default:
                ok = 1'b0;
        endcase
    end

endmodule : code_window_check
`default_nettype wire

// File: host_model.sv
// Word-transaction host that drives the configuration command bank.
// Assumes the bank takes a request at one edge and answers a read one
// cycle later, as the bank's interface promises.
`timescale 1ns/1ps
`default_nettype none

module host_model
(
    input wire logic clk,
    input wire logic rd_valid,
    input wire logic [15:0] rd_data,
    input wire logic hit,
    output logic valid,
    output logic write,
    output logic [7:0] code,
    output logic [15:0] data,
    output logic [7:0] page,
    output logic [7:0] phase,
    output logic clear
);
    initial
    begin
        {valid, write, code, data, page, phase, clear} = '0;
    end

    // Page and phase go out with the request, so they are settled when taken.
    task automatic xfer(input logic wr, input logic [7:0] c,
        input logic [15:0] w, input logic [7:0] pg, input logic [7:0] ph,
        input logic clr, output logic [15:0] rd, output logic got,
        output logic hs);
        @(posedge clk);
        {valid, write, code, data} <= {1'b1, wr, c, w};
        {page, phase, clear} <= {pg, ph, clr};
        #1;
        hs = hit;
        @(posedge clk);
        valid <= 1'b0;
        clear <= 1'b0;
        // A released data bus must not keep showing the last word.
        data <= ~w;
        #1;
        got = rd_valid;
        rd = rd_data;
    endtask : xfer
endmodule : host_model

`default_nettype wire

// File: pmbus_config_cmd_bank.sv
// Configuration command bank: switching frequency, turn-on voltage,
// current-sense gain and offset, and overvoltage limit readback.
// Assumes the word transaction engine, page and phase registers, status
// read path and nonvolatile store live outside and share MCLK.
//
// Operation
// - Frequency word: exponent reads zero, 11-bit mantissa in kilohertz.
// - Frequency codes 012Ch to 03E8h in 50 kHz steps only.
// - Turn-on word: exponent reads minus two, mantissa writable.
// - Turn-on codes F010h or F015h to F02Dh in 1 V steps.
// - Turn-on setting is one copy shared by both channels.
// - Page 00h channel A, 01h channel B, FFh writes both.
// - Registers are served by word reads and word writes only.
// - Gain exponent minus six, codes D131h to D150h accepted.
// - One gain per channel; host selects phase 80h.
// - Offset exponent reads minus three, step 0.125 A.
// - Offset held per phase and total; FFh writes all phases.
// - Single-phase offsets E800h-E808h and EFF9h-EFFFh only.
// - Total offsets even codes E800h-E820h and EFE2h-EFFEh only.
// - Rejected write leaves register, sets fault flags, raises alert.
// - Overvoltage limit reads back per channel in VID code.
// - Any write to the overvoltage limit is rejected as invalid.
`timescale 1ns/1ps
`default_nettype none
`include "cfg_cmd_map.svh"

module pmbus_config_cmd_bank
#(
    parameter int NPHASE = 6
)
(
    input wire logic MCLK,
    input wire logic RST,
    input wire logic CMD_VALID,
    input wire logic CMD_WRITE,
    input wire logic [7:0] CMD_CODE,
    input wire logic [15:0] WR_DATA,
    input wire logic [7:0] PAGE,
    input wire logic [7:0] PHASE,
    input wire logic CLEAR_FAULTS,
    input wire logic [10:0] NVM_FREQ,
    input wire logic [10:0] NVM_TURNON,
    input wire logic [10:0] NVM_GAIN,
    input wire logic [10:0] NVM_OFFSET,
    input wire logic [7:0] OV_VID_A,
    input wire logic [7:0] OV_VID_B,
    output logic CMD_HIT,
    output logic RD_VALID,
    output logic [15:0] RD_DATA,
    output logic COMM_FAULT,
    output logic SUMMARY_FAULT,
    output logic HOST_ALERT_OUT,
    output logic [10:0] FREQ_A,
    output logic [10:0] FREQ_B,
    output logic [10:0] TURNON,
    output logic [10:0] GAIN_A,
    output logic [10:0] GAIN_B,
    output logic [(NPHASE+1)*11-1:0] OFFSET_A,
    output logic [(NPHASE+1)*11-1:0] OFFSET_B
);
    import cfg_cmd_pkg::*;

    // ****************************************************************
    // Parameter check
    // ****************************************************************
    // Phase codes are one byte and 80h means total, so at most 128 phases.
    generate
        if (NPHASE < 1 || NPHASE > 128)
        begin : g_bad_nphase
            $error("NPHASE must lie between 1 and 128");
        end
    endgenerate

    localparam logic [7:0] NPH8 = 8'(NPHASE);

    // Entry NPHASE of each channel holds the total-current offset.
    typedef struct packed {
        logic [1:0][10:0] freq;
        logic [10:0] turnon;
        logic [1:0][10:0] gain;
        logic [1:0][NPHASE:0][10:0] ofs;
        logic [15:0] rd_data;
        logic rd_valid;
        logic cml;
        logic summary;
    } state_t;

    state_t q;
    state_t d;
    state_t rst_val;

    sel_t sel;
    logic [1:0] ch_wr;
    logic ch_rd;
    logic page_ok;
    logic phase_total;
    logic phase_all;
    logic phase_ok;
    logic code_ok;
    logic wr_ok;
    logic wr_bad;
    logic [1:0][NPHASE:0] ofs_we;
    logic [7:0] rd_idx;

    // ****************************************************************
    // Command decode
    // ****************************************************************
    always_comb
    begin
        if (CMD_CODE == `CMD_FREQ)
            sel = SEL_FREQ;
        else if (CMD_CODE == `CMD_TURNON)
            sel = SEL_TURNON;
        else if (CMD_CODE == `CMD_GAIN)
            sel = SEL_GAIN;
        else if (CMD_CODE == `CMD_OFFSET)
            sel = SEL_OFFSET;
        else if (CMD_CODE == `CMD_OVLIM)
            sel = SEL_OVLIM;
        else
            sel = SEL_NONE;
    end

    // Paging: FFh reaches both channels on write and reads channel A.
    always_comb
    begin
        page_ok = 1'b1;
        ch_rd = 1'b0;
        ch_wr = 2'b00;
        if (PAGE == `PAGE_A)
            ch_wr = 2'b01;
        else if (PAGE == `PAGE_B)
        begin
            ch_wr = 2'b10;
            ch_rd = 1'b1;
        end
        else if (PAGE == `PAGE_ALL)
            ch_wr = 2'b11;
        else
            page_ok = 1'b0;
    end

    always_comb
    begin
        phase_total = PHASE == `PHASE_TOTAL;
        phase_all = PHASE == `PHASE_ALL;
        phase_ok = phase_total || phase_all || PHASE < NPH8;
        if (phase_total)
            rd_idx = NPH8;
        else if (PHASE < NPH8)
            rd_idx = PHASE;
        else
            rd_idx = 8'h00;
    end

    code_window_check u_check
    (
        .sel(sel),
        .total(phase_total),
        .word(WR_DATA),
        .ok(code_ok)
    );

    // The turn-on word ignores the page; the others need a legal page.
    always_comb
    begin
        wr_ok = 1'b0;
        if (CMD_VALID && CMD_WRITE && code_ok)
        begin
            if (sel == SEL_TURNON)
                wr_ok = 1'b1;
            else if (sel == SEL_OFFSET)
                wr_ok = page_ok && phase_ok;
            else
                wr_ok = page_ok;
        end
        // Any addressed write that is not taken counts as invalid.
        wr_bad = CMD_VALID && CMD_WRITE && sel != SEL_NONE &&
                 !wr_ok;
    end

    // ****************************************************************
    // Per-entry offset write enables
    // ****************************************************************
    genvar gc;
    genvar gp;
    generate
        for (gc = 0; gc < 2; gc++)
        begin : g_ch
            for (gp = 0; gp <= NPHASE; gp++)
            begin : g_ph
                if (gp == NPHASE)
                begin : g_tot
                    assign ofs_we[gc][gp] = wr_ok && sel == SEL_OFFSET &&
                        ch_wr[gc] && phase_total;
                end
                else
                begin : g_one
                    assign ofs_we[gc][gp] = wr_ok && sel == SEL_OFFSET &&
                        ch_wr[gc] &&
                        (phase_all || PHASE == 8'(gp));
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        rst_val = '0;
        for (int c = 0; c < 2; c++)
        begin
            rst_val.freq[c] = NVM_FREQ;
            rst_val.gain[c] = NVM_GAIN;
            for (int p = 0; p <= NPHASE; p++)
                rst_val.ofs[c][p] = NVM_OFFSET;
        end
        rst_val.turnon = NVM_TURNON;
    end

    always_comb
    begin
        d = q;
        d.rd_valid = 1'b0;
        if (wr_ok)
        begin
            for (int c = 0; c < 2; c++)
            begin
                if (ch_wr[c] && sel == SEL_FREQ)
                    d.freq[c] = WR_DATA[`MAN_MSB:`MAN_LSB];
                // Phase is not looked at: the gain is common per channel.
                if (ch_wr[c] && sel == SEL_GAIN)
                    d.gain[c] = WR_DATA[`MAN_MSB:`MAN_LSB];
                for (int p = 0; p <= NPHASE; p++)
                    if (ofs_we[c][p])
                        d.ofs[c][p] = WR_DATA[`MAN_MSB:`MAN_LSB];
            end
            if (sel == SEL_TURNON)
                d.turnon = WR_DATA[`MAN_MSB:`MAN_LSB];
        end
        // Clear first so that a fault in the same cycle still sets.
        if (CLEAR_FAULTS)
        begin
            d.cml = 1'b0;
            d.summary = 1'b0;
        end
        if (wr_bad)
        begin
            d.cml = 1'b1;
            d.summary = 1'b1;
        end
        // Reads return the fixed exponent above the stored mantissa; the limit reads 00h above its VID code.
        if (CMD_VALID && !CMD_WRITE && sel != SEL_NONE)
        begin
            d.rd_valid = 1'b1;
            case (sel)
                SEL_FREQ:
                    d.rd_data = {`FREQ_EXP, q.freq[ch_rd]};
                SEL_TURNON:
                    d.rd_data = {`TURNON_EXP, q.turnon};
                SEL_GAIN:
                    d.rd_data = {`GAIN_EXP, q.gain[ch_rd]};
                SEL_OFFSET:
                    d.rd_data = {`OFFSET_EXP,
                                 q.ofs[ch_rd][rd_idx]};
                default:
                    d.rd_data = {8'h00,
                                 ch_rd ? OV_VID_B : OV_VID_A};
            endcase
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (RST)
            q <= rst_val;
        else
            q <= d;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    always_comb
    begin
        CMD_HIT = CMD_VALID && sel != SEL_NONE;
        RD_VALID = q.rd_valid;
        RD_DATA = q.rd_data;
        COMM_FAULT = q.cml;
        SUMMARY_FAULT = q.summary;
        HOST_ALERT_OUT = q.cml;
        FREQ_A = q.freq[0];
        FREQ_B = q.freq[1];
        TURNON = q.turnon;
        GAIN_A = q.gain[0];
        GAIN_B = q.gain[1];
        OFFSET_A = q.ofs[0];
        OFFSET_B = q.ofs[1];
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RST);

    property p_freq_read;
        CMD_VALID && !CMD_WRITE && CMD_CODE == `CMD_FREQ && PAGE == `PAGE_B
        |=> RD_VALID && RD_DATA == {5'b00000, $past(q.freq[1])};
    endproperty
    a_freq_read: assert property (p_freq_read)
        else $error("frequency read word wrong");

    property p_freq_reject;
        CMD_VALID && CMD_WRITE && CMD_CODE == `CMD_FREQ &&
        PAGE == `PAGE_A && WR_DATA == 16'h012D
        |=> q.freq[0] == $past(q.freq[0]) && COMM_FAULT && HOST_ALERT_OUT;
    endproperty
    a_freq_reject: assert property (p_freq_reject)
        else $error("off-step frequency code was taken");

    property p_turnon_exp;
        CMD_VALID && !CMD_WRITE && CMD_CODE == `CMD_TURNON
        |=> RD_VALID ##0 RD_DATA[15:11] == 5'b11110;
    endproperty
    a_turnon_exp: assert property (p_turnon_exp)
        else $error("turn-on exponent wrong");

    property p_turnon_shared;
        CMD_VALID && CMD_WRITE && CMD_CODE == `CMD_TURNON &&
        WR_DATA == 16'hF019 && PAGE == 8'h07
        |=> TURNON == 11'h019 && !$rose(COMM_FAULT);
    endproperty
    a_turnon_shared: assert property (p_turnon_shared)
        else $error("turn-on write depended on page");

    property p_page_b;
        CMD_VALID && CMD_WRITE && CMD_CODE == `CMD_FREQ &&
        PAGE == `PAGE_B && WR_DATA == 16'h0190
        |=> FREQ_B == 11'h190 && FREQ_A == $past(FREQ_A);
    endproperty
    a_page_b: assert property (p_page_b)
        else $error("page B write reached the wrong channel");

    property p_gain_both;
        CMD_VALID && CMD_WRITE && CMD_CODE == `CMD_GAIN &&
        PAGE == `PAGE_ALL && WR_DATA == 16'hD150
        |=> GAIN_A == 11'h150 && GAIN_B == 11'h150;
    endproperty
    a_gain_both: assert property (p_gain_both)
        else $error("gain broadcast failed");

    property p_ofs_total;
        CMD_VALID && CMD_WRITE && CMD_CODE == `CMD_OFFSET &&
        PAGE == `PAGE_A && PHASE == `PHASE_TOTAL && WR_DATA == 16'hEFE2
        |=> q.ofs[0][NPHASE] == 11'h7E2 && q.ofs[0][0] == $past(q.ofs[0][0]);
    endproperty
    a_ofs_total: assert property (p_ofs_total)
        else $error("total offset write wrong");

    property p_ovlim_write;
        CMD_VALID && CMD_WRITE && CMD_CODE == `CMD_OVLIM
        |=> COMM_FAULT && SUMMARY_FAULT && HOST_ALERT_OUT;
    endproperty
    a_ovlim_write: assert property (p_ovlim_write)
        else $error("limit write not flagged");

    property p_ov_read;
        CMD_VALID && !CMD_WRITE && CMD_CODE == `CMD_OVLIM && PAGE == `PAGE_B
        |=> RD_DATA == {8'h00, $past(OV_VID_B)};
    endproperty
    a_ov_read: assert property (p_ov_read)
        else $error("limit readback wrong");

    property p_flag_sticky;
        COMM_FAULT && !CLEAR_FAULTS |=> COMM_FAULT;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("fault flag dropped without a clear");

    c_freq_write: cover property (CMD_VALID && CMD_WRITE &&
        CMD_CODE == `CMD_FREQ && wr_ok);
    c_ofs_all: cover property (CMD_VALID && CMD_WRITE &&
        CMD_CODE == `CMD_OFFSET && phase_all && wr_ok);
    c_reject: cover property (wr_bad ##1 COMM_FAULT);
    c_set_clear: cover property (wr_bad && CLEAR_FAULTS);

endmodule : pmbus_config_cmd_bank
`default_nettype wire

// File: pmbus_config_cmd_bank_tb_top.sv
// Self-checking bench for the configuration command bank.
// Assumes host_model issues the word transactions; NPHASE is set to 3.
`timescale 1ns/1ps
`default_nettype none
`include "cfg_cmd_map.svh"

module pmbus_config_cmd_bank_tb_top;
    localparam int NP = 3;
    localparam logic [7:0] CMDS[6] = '{8'h33, 8'h35, 8'h38, 8'h39, 8'h40,
        8'h34};
    localparam logic [7:0] PGS[4] = '{8'h00, 8'h01, 8'hFF, 8'h02};
    localparam logic [7:0] PHS[5] = '{8'h00, 8'h02, 8'h80, 8'hFF, 8'h03};
    localparam logic [31:0] CORNER[26] = '{32'h3300012C, 32'h330003E8,
        32'h330003E9, 32'h3300012B, 32'h33000190, 32'h3300092C,
        32'h3500F010, 32'h3500F011, 32'h3500F02D, 32'h3500F031,
        32'h3880D130, 32'h3880D131, 32'h3880D150, 32'h3880D151,
        32'h3900E808, 32'h3902E809, 32'h39FFEFF9, 32'h3901EFF8,
        32'h3980E820, 32'h3980E822, 32'h3980EFE2, 32'h3980E801,
        32'h3980EFE1, 32'h3903E800, 32'h40000000, 32'h3400FFFF};
    logic MCLK, RST;
    logic [10:0] nvm[4];
    logic [7:0] ov[2];
    wire logic v, wr, clr, hit, rdv, cf, sf, al;
    wire logic [7:0] code, pg, ph;
    wire logic [15:0] wd, rdd;
    wire logic [10:0] fa, fb, tn, ga, gb;
    wire logic [(NP+1)*11-1:0] oa, ob;
    logic [10:0] e_f[2], e_t, e_g[2], e_o[2][NP+1];
    logic e_fl;
    logic [15:0] e_rd;
    int failures, checks;

    host_model u_host (.clk(MCLK), .rd_valid(rdv), .rd_data(rdd),
        .hit(hit), .valid(v), .write(wr), .code(code), .data(wd),
        .page(pg), .phase(ph), .clear(clr));

    pmbus_config_cmd_bank #(.NPHASE(NP)) u_dut (.MCLK(MCLK), .RST(RST),
        .CMD_VALID(v), .CMD_WRITE(wr), .CMD_CODE(code), .WR_DATA(wd),
        .PAGE(pg), .PHASE(ph), .CLEAR_FAULTS(clr), .NVM_FREQ(nvm[0]),
        .NVM_TURNON(nvm[1]), .NVM_GAIN(nvm[2]), .NVM_OFFSET(nvm[3]),
        .OV_VID_A(ov[0]), .OV_VID_B(ov[1]), .CMD_HIT(hit), .RD_VALID(rdv),
        .RD_DATA(rdd), .COMM_FAULT(cf), .SUMMARY_FAULT(sf),
        .HOST_ALERT_OUT(al), .FREQ_A(fa), .FREQ_B(fb), .TURNON(tn),
        .GAIN_A(ga), .GAIN_B(gb), .OFFSET_A(oa), .OFFSET_B(ob));

    initial
    begin
        MCLK = 1'b0;
        forever #5 MCLK = ~MCLK;
    end

    // ********
    // Checking
    // ********
    task automatic check(input string n, input logic [63:0] e,
        input logic [63:0] s);
        checks++;
        if (s !== e)
        begin
            failures++;
            $display("CHECK FAILED %s expected %0h seen %0h", n, e, s);
        end
    endtask : check

    task automatic complete_run();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run

    function automatic logic [(NP+1)*11-1:0] pk(input int c);
        for (int p = 0; p <= NP; p++)
            pk[p*11 +: 11] = e_o[c][p];
    endfunction : pk

    task automatic cmp_all();
        check("FREQ_A", e_f[0], fa);
        check("FREQ_B", e_f[1], fb);
        check("TURNON", e_t, tn);
        check("GAIN_A", e_g[0], ga);
        check("GAIN_B", e_g[1], gb);
        check("OFFSET_A", pk(0), oa);
        check("OFFSET_B", pk(1), ob);
        check("COMM_FAULT", e_fl, cf);
        check("SUMMARY_FAULT", e_fl, sf);
        check("HOST_ALERT_OUT", e_fl, al);
    endtask : cmp_all

    // The complete word is judged, so a wrong exponent is refused too.
    function automatic logic good(input logic [7:0] c, input logic t,
        input logic [15:0] w);
        case (c)
            8'h33: good = w >= 16'h012C && w <= 16'h03E8
                && (w - 16'h012C) % 50 == 0;
            8'h35: good = w == 16'hF010 || (w >= 16'hF015
                && w <= 16'hF02D && (w - 16'hF015) % 4 == 0);
            8'h38: good = w >= 16'hD131 && w <= 16'hD150;
            8'h39: good = t ? !w[0] && ((w >= 16'hE800 && w <= 16'hE820)
                || (w >= 16'hEFE2 && w <= 16'hEFFE))
                : (w >= 16'hE800 && w <= 16'hE808) || w >= 16'hEFF9
                && w <= 16'hEFFF;
            default: good = 1'b0;
        endcase
    endfunction : good

    // Legal codes for 33h, 35h, 38h and 39h, as a well-behaved host writes them; a random word for 40h and 34h.
    function automatic logic [15:0] pick(input logic [7:0] c, input logic t);
        int unsigned k;
        k = $urandom;
        case (c)
            8'h33: pick = 16'h012C + 16'(50 * (k % 15));
            8'h35: pick = k % 8 == 0 ? 16'hF010
                : 16'hF011 + 16'(4 * (k % 8));
            8'h38: pick = 16'hD131 + 16'(k % 32);
            8'h39: pick = t ? (k % 32 < 17 ? 16'hE800 + 16'(2 * (k % 32))
                : 16'hEFC0 + 16'(2 * (k % 32)))
                : (k % 16 < 9 ? 16'hE800 + 16'(k % 16)
                : 16'hEFF0 + 16'(k % 16));
            default: pick = 16'(k);
        endcase
    endfunction : pick

    // ********
    // Transfers
    // ********
    task automatic do_wr(input logic [7:0] c, input logic [7:0] p,
        input logic [7:0] h, input logic [15:0] w, input logic k);
        logic [15:0] rd;
        logic got, hs, known, bad, t;
        known = c inside {8'h33, 8'h35, 8'h38, 8'h39, 8'h40};
        t = h == 8'h80;
        bad = known && (c == 8'h40 || !good(c, t, w)
            || (c != 8'h35 && !(p inside {8'h00, 8'h01, 8'hFF}))
            || (c == 8'h39 && !(h < NP || t || h == 8'hFF)));
        if (known && !bad)
            for (int ch = 0; ch < 2; ch++)
                if (p == 8'hFF || p == ch || c == 8'h35)
                    case (c)
                        8'h33: e_f[ch] = w[10:0];
                        8'h35: e_t = w[10:0];
                        8'h38: e_g[ch] = w[10:0];
                        default:
                            for (int q = 0; q <= NP; q++)
                                if ((t && q == NP) || h == q
                                    || (h == 8'hFF && q < NP))
                                    e_o[ch][q] = w[10:0];
                    endcase
        e_fl = bad ? 1'b1 : (k ? 1'b0 : e_fl);
        u_host.xfer(1'b1, c, w, p, h, k, rd, got, hs);
        check("CMD_HIT", known, hs);
        check("RD_VALID on write", 1'b0, got);
        cmp_all();
    endtask : do_wr

    task automatic do_rd(input logic [7:0] c, input logic [7:0] p,
        input logic [7:0] h);
        logic [15:0] rd, e;
        logic got, hs, known;
        int ch, q;
        known = c inside {8'h33, 8'h35, 8'h38, 8'h39, 8'h40};
        ch = p == 8'h01 ? 1 : 0;
        q = h == 8'h80 ? NP : (h < NP ? int'(h) : 0);
        case (c)
            8'h33: e = {5'b00000, e_f[ch]};
            8'h35: e = {5'b11110, e_t};
            8'h38: e = {5'b11010, e_g[ch]};
            8'h39: e = {5'b11101, e_o[ch][q]};
            default: e = {8'h00, ov[ch]};
        endcase
        // An unknown code gets no answer, so the last answer stays.
        if (known)
            e_rd = e;
        u_host.xfer(1'b0, c, 16'($urandom), p, h, 1'b0, rd, got, hs);
        check("CMD_HIT on read", known, hs);
        check("RD_VALID", known, got);
        check("RD_DATA", e_rd, rd);
    endtask : do_rd

    task automatic do_reset();
        RST <= 1'b1;
        foreach (nvm[i])
            nvm[i] <= 11'($urandom);
        repeat (2) @(posedge MCLK);
        RST <= 1'b0;
        #1;
        e_f = '{nvm[0], nvm[0]};
        e_t = nvm[1];
        e_g = '{nvm[2], nvm[2]};
        foreach (e_o[c, p])
            e_o[c][p] = nvm[3];
        e_fl = 1'b0;
        e_rd = 16'h0000;
        check("RD_DATA after reset", 16'h0000, rdd);
        cmp_all();
        $display("test reset done");
    endtask : do_reset

    initial
    begin
        #200us;
        failures++;
        $display("CHECK FAILED watchdog expected finish seen hang");
        complete_run();
    end

    initial
    begin
        logic [7:0] c, p, h;
        logic [15:0] w;
        RST = 1'b1;
        ov = '{8'h5A, 8'hA5};
        foreach (nvm[i])
            nvm[i] = 11'h000;
        void'($urandom(54157));
        do_reset();
        foreach (CORNER[i])
        begin
            do_wr(CORNER[i][31:24], PGS[i % 4], CORNER[i][23:16],
                CORNER[i][15:0], 1'b0);
            do_rd(CORNER[i][31:24], PGS[i % 4], CORNER[i][23:16]);
            if (e_fl)
                do_wr(8'h34, 8'h00, 8'h00, 16'h0000, 1'b1);
        end
        do_wr(8'h33, 8'h00, 8'h00, 16'h012D, 1'b0);
        do_wr(8'h33, 8'h01, 8'h00, 16'h0190, 1'b1);
        do_wr(8'h35, 8'h07, 8'h00, 16'hF019, 1'b0);
        do_wr(8'h38, 8'hFF, 8'h80, 16'hD150, 1'b0);
        $display("test corner done");
        for (int i = 0; i < 300; i++)
        begin
            c = CMDS[$urandom % 6];
            p = PGS[$urandom % 4];
            h = $urandom % 3 == 0 ? 8'($urandom) : PHS[$urandom % 5];
            w = pick(c, h == 8'h80);
            case ($urandom % 4)
                0: w = 16'($urandom);
                1: w = w ^ 16'h0800;
                2: w = w + 16'h0001 - 16'($urandom % 3);
                default: ;
            endcase
            ov[i % 2] <= 8'($urandom);
            do_wr(c, p, h, w, $urandom % 8 == 0);
            do_rd(c, p, h);
        end
        $display("test random done");
        do_reset();
        complete_run();
    end
endmodule : pmbus_config_cmd_bank_tb_top

`default_nettype wire
